// file: design/gtc_timer.sv
`timescale 1ns/10ps
`include "gtc_cfg.svh"
// How it works
// - counter sampled into output flops every cycle, reads always coherent.
// - gate enable makes the gate govern counting; polarity picks active level.
// - outside toggle mode, gated count increments only while gate level equals the polarity bit.
// - two-bit select picks pin, timer0 overflow, comparator one or two.
// - timer0 wrap from FFh to 00h gives a one-cycle gate pulse.
// - each comparator gate source may be re-timed to the timer clock or used after its two sync flops.
// - toggle mode flips a flop per rising gate edge; clear holds it clear.
// - go flag armed after single-pulse set; counting starts at next rising edge.
// - trailing edge clears go flag and blocks further gate counting.
// - toggle and single-pulse combine so a full gate period is counted.
// - gate level status always visible, even with gating disabled.
// - falling gate level sets the gate-event flag; enable requests interrupt.
// - counter wraps FFFFh to 0000h and sets the overflow flag.
// - overflow interrupt needs timer on and all three enables.
// - in sleep only unsynchronised external counting runs; overflow wakes.
// - crystal oscillator enable stays honoured during sleep.
// - counter copied to capture pair on capture; compare match flagged.
// - compare trigger clears counter without setting overflow flag.
// - software count write wins over a trigger clear in the same cycle.
// - timer off stops counting and clears the toggle flop.
module gtc_timer #(
  parameter int CNT_W = `GTC_CNT_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic timer_clock,
  input wire logic gating_pin,
  input wire logic [`GTC_BYTE_W-1:0] eight_bit_timer_count,
  input wire logic comparator_one_out,
  input wire logic comparator_two_out,
  input wire logic cmp_one_sync_enable,
  input wire logic cmp_two_sync_enable,
  input wire logic timer_on_control,
  input wire logic gating_enable,
  input wire logic gating_polarity,
  input wire logic gating_toggle_mode,
  input wire logic gating_single_pulse_mode,
  input wire logic [1:0] gating_source_select,
  input wire logic sync_disable_control,
  input wire logic clock_source_external,
  input wire logic crystal_osc_enable,
  input wire logic sleep_mode,
  input wire logic go_set,
  input wire logic go_clear,
  input wire logic count_low_byte_we,
  input wire logic count_high_byte_we,
  input wire logic [`GTC_BYTE_W-1:0] count_wdata,
  input wire logic gating_event_irq_enable,
  input wire logic gating_event_flag_clear,
  input wire logic overflow_irq_enable,
  input wire logic overflow_flag_clear,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic capture_event,
  input wire logic auto_conv_trigger,
  input wire logic [CNT_W-1:0] compare_value,
  output logic [`GTC_BYTE_W-1:0] count_low_byte,
  output logic [`GTC_BYTE_W-1:0] count_high_byte,
  output logic [`GTC_BYTE_W-1:0] capture_compare_low,
  output logic [`GTC_BYTE_W-1:0] capture_compare_high,
  output logic compare_match,
  output logic acquisition_go_flag,
  output logic gating_level_status,
  output logic gating_event_flag,
  output logic overflow_flag,
  output logic gating_event_irq,
  output logic overflow_irq,
  output logic wake_request,
  output logic crystal_osc_run
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] tclk_sync_reg;
  logic [1:0] pin_sync_reg;
  logic tclk_prev_reg;
  logic [`GTC_BYTE_W-1:0] t0_prev_reg;
  logic t0_pulse_reg;

  // timer clock and gate pin each pass two flops; timer0 count is not synchronised
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tclk_sync_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      tclk_sync_reg <= {tclk_sync_reg[0], timer_clock};
      pin_sync_reg <= {pin_sync_reg[0], gating_pin};
    end
  end

  // ----------------------------------------
  // gate source selection
  // ----------------------------------------
  logic tclk_rise;
  logic t0_wrap;
  logic comparator_one_gate;
  logic comparator_two_gate;
  logic sel_pin;
  logic sel_t0;
  logic sel_cmp1;
  logic sel_cmp2;
  logic gate_src;

  // rising edge of the synchronised timer clock, one cycle wide
  assign tclk_rise = tclk_sync_reg[1] & ~tclk_prev_reg;
  // wrap seen when the last timer0 value was the top and now is zero
  assign t0_wrap = (t0_prev_reg == `GTC_T0_MAX) && (eight_bit_timer_count == `GTC_T0_ZERO);

  // one-hot decode of the source select field
  assign sel_pin = (gating_source_select == `GTC_SRC_PIN);
  assign sel_t0 = (gating_source_select == `GTC_SRC_T0);
  assign sel_cmp1 = (gating_source_select == `GTC_SRC_CMP1);
  assign sel_cmp2 = (gating_source_select == `GTC_SRC_CMP2);

  // exactly one term is live for any select value
  assign gate_src = (sel_pin & pin_sync_reg[1]) |
                    (sel_t0 & t0_pulse_reg) |
                    (sel_cmp1 & comparator_one_gate) |
                    (sel_cmp2 & comparator_two_gate);

  // timer clock edge and timer0 wrap pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tclk_prev_reg <= 1'h0;
      t0_prev_reg <= `GTC_T0_ZERO;
      t0_pulse_reg <= 1'h0;
    end else begin
      tclk_prev_reg <= tclk_sync_reg[1];
      t0_prev_reg <= eight_bit_timer_count;
      t0_pulse_reg <= t0_wrap;
    end
  end

  // ----------------------------------------
  // comparator gate paths
  // ----------------------------------------
  logic [`GTC_N_CMP-1:0] cmp_raw;
  logic [`GTC_N_CMP-1:0] cmp_sync_en;
  logic [`GTC_N_CMP-1:0] cmp_gate;

  // comparator levels and their sync options as vectors
  assign cmp_raw = {comparator_two_out, comparator_one_out};
  assign cmp_sync_en = {cmp_two_sync_enable, cmp_one_sync_enable};

  // one path per comparator
  for (genvar i = 0; i < `GTC_N_CMP; i++) begin : g_cmp
    logic [1:0] meta_reg;
    logic tsync_reg;
    logic raw_gate;

    // level after the two sync flops
    assign raw_gate = meta_reg[1];
    // re-timed copy only moves on a timer clock edge
    assign cmp_gate[i] = cmp_sync_en[i] ? tsync_reg : raw_gate;

    // two sync flops, then timer clock re-timing
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        meta_reg <= 2'h0;
        tsync_reg <= 1'h0;
      end else begin
        meta_reg <= {meta_reg[0], cmp_raw[i]};
        if (tclk_rise) begin
          tsync_reg <= raw_gate;
        end
      end
    end
  end

  // named gate levels for the source mux
  assign comparator_one_gate = cmp_gate[0];
  assign comparator_two_gate = cmp_gate[1];

  // ----------------------------------------
  // polarity, toggle and single pulse
  // ----------------------------------------
  logic src_pol;
  logic src_pol_prev_reg;
  logic src_rise;
  logic toggle_reg;
  logic toggle_next;
  logic gate_lvl;
  logic gate_lvl_prev_reg;
  logic gate_fall;
  gtc_pkg::gtc_sp_t sp_reg;
  gtc_pkg::gtc_sp_t sp_next;
  logic sp_done;
  logic gate_open;

  assign src_pol = ~(gate_src ^ gating_polarity);
  assign src_rise = src_pol & ~src_pol_prev_reg;
  // toggle flop cleared while mode off or timer off
  assign toggle_next = (!gating_toggle_mode || !timer_on_control) ? 1'h0 :
                       src_rise ? ~toggle_reg : toggle_reg;
  // toggle output replaces the source so a full period is one level
  assign gate_lvl = gating_toggle_mode ? toggle_reg : src_pol;
  // a falling gate level ends a gate event
  assign gate_fall = gate_lvl_prev_reg & ~gate_lvl;
  assign gating_level_status = gate_lvl;
  assign sp_done = (sp_reg == gtc_pkg::GTC_SP_ACTIVE) && gate_fall;
  assign gate_open = !gating_single_pulse_mode ? gate_lvl :
                     (sp_reg == gtc_pkg::GTC_SP_ACTIVE) && gate_lvl;

  // single-pulse sequencing
  always_comb begin
    sp_next = sp_reg;
    case (sp_reg)
      gtc_pkg::GTC_SP_IDLE: begin
        if (go_set && gating_single_pulse_mode) begin
          sp_next = gtc_pkg::GTC_SP_ARMED;
        end
      end
      gtc_pkg::GTC_SP_ARMED: begin
        if (go_clear) begin
          sp_next = gtc_pkg::GTC_SP_IDLE;
        end else if (gate_lvl && !gate_lvl_prev_reg) begin
          sp_next = gtc_pkg::GTC_SP_ACTIVE;
        end
      end
      gtc_pkg::GTC_SP_ACTIVE: begin
        if (sp_done || go_clear) begin
          sp_next = gtc_pkg::GTC_SP_IDLE;
        end
      end
      default: begin
        sp_next = gtc_pkg::GTC_SP_IDLE;
      end
    endcase
  end

  // go flag reads high while armed or counting
  assign acquisition_go_flag = (sp_reg != gtc_pkg::GTC_SP_IDLE);

  // gate state registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_pol_prev_reg <= 1'h0;
      toggle_reg <= 1'h0;
      gate_lvl_prev_reg <= 1'h0;
      sp_reg <= gtc_pkg::GTC_SP_IDLE;
    end else begin
      src_pol_prev_reg <= src_pol;
      toggle_reg <= toggle_next;
      gate_lvl_prev_reg <= gate_lvl;
      sp_reg <= sp_next;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] capture_reg;
  logic asleep_block;
  logic count_en;
  logic incr;
  logic wrap;
  logic cpu_write;

  // sleep leaves only unsynchronised external counting alive
  assign asleep_block = sleep_mode && !(sync_disable_control && clock_source_external);
  // gate only matters while gating is enabled
  assign count_en = timer_on_control && !asleep_block && (!gating_enable || gate_open);
  assign incr = count_en && tclk_rise;
  // overflow only on a real increment from the top
  assign wrap = incr && (count_reg == `GTC_CNT_MAX);
  // either byte strobe counts as a software write
  assign cpu_write = count_low_byte_we || count_high_byte_we;

  // write beats trigger, trigger beats increment
  always_comb begin
    count_next = count_reg;
    if (cpu_write) begin
      if (count_low_byte_we) begin
        count_next[`GTC_BYTE_W-1:0] = count_wdata;
      end
      if (count_high_byte_we) begin
        count_next[CNT_W-1:`GTC_BYTE_W] = count_wdata;
      end
    end else if (auto_conv_trigger) begin
      count_next = `GTC_CNT_ZERO;
    end else if (incr) begin
      count_next = count_reg + 1'b1;
    end
  end

  // live compare against the counter, not the read-back copy
  assign compare_match = (count_reg == compare_value);

  // count, capture and read-back flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= `GTC_CNT_ZERO;
      capture_reg <= `GTC_CNT_ZERO;
      count_low_byte <= `GTC_T0_ZERO;
      count_high_byte <= `GTC_T0_ZERO;
    end else begin
      count_reg <= count_next;
      if (capture_event) begin
        capture_reg <= count_reg;
      end
      count_low_byte <= count_reg[`GTC_BYTE_W-1:0];
      count_high_byte <= count_reg[CNT_W-1:`GTC_BYTE_W];
    end
  end

  // capture pair read straight from its register
  assign capture_compare_low = capture_reg[`GTC_BYTE_W-1:0];
  assign capture_compare_high = capture_reg[CNT_W-1:`GTC_BYTE_W];

  // ----------------------------------------
  // flags and requests
  // ----------------------------------------
  // set beats clear on both flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gating_event_flag <= 1'h0;
      overflow_flag <= 1'h0;
    end else begin
      gating_event_flag <= gate_fall | (gating_event_flag & ~gating_event_flag_clear);
      overflow_flag <= (wrap && !cpu_write && !auto_conv_trigger) |
                       (overflow_flag & ~overflow_flag_clear);
    end
  end

  // gate event request follows the flag and the enable chain
  assign gating_event_irq = gating_event_flag && gating_event_irq_enable &&
                            peripheral_irq_enable && global_irq_enable;
  // overflow request needs the timer on as well
  assign overflow_irq = overflow_flag && overflow_irq_enable && timer_on_control &&
                        peripheral_irq_enable && global_irq_enable;
  // wake needs no global enable; the core decides on service entry
  assign wake_request = sleep_mode && overflow_flag && overflow_irq_enable &&
                        timer_on_control && peripheral_irq_enable;
  // oscillator left alone by sleep and by the sync control
  assign crystal_osc_run = crystal_osc_enable;

endmodule : gtc_timer

// file: design/gtc_cfg.svh
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH
// ----------------------------------------
// widths and encodings
// ----------------------------------------
`define GTC_CNT_W 16
`define GTC_BYTE_W 8
`define GTC_CNT_ZERO 16'h0000
`define GTC_CNT_MAX 16'hFFFF
`define GTC_T0_MAX 8'hFF
`define GTC_T0_ZERO 8'h00
`define GTC_SRC_PIN 2'h0
`define GTC_SRC_T0 2'h1
`define GTC_SRC_CMP1 2'h2
`define GTC_SRC_CMP2 2'h3
`define GTC_N_CMP 2
`endif

// file: design/gtc_pkg.sv
package gtc_pkg;
  // single-pulse acquisition phases
  typedef enum logic [1:0] {
    GTC_SP_IDLE,
    GTC_SP_ARMED,
    GTC_SP_ACTIVE
  } gtc_sp_t;
endpackage : gtc_pkg

// file: test/gtc_props.sv
`timescale 1ns/10ps
module gtc_props #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic timer_on_control,
  input wire logic count_low_byte_we,
  input wire logic count_high_byte_we,
  input wire logic [7:0] count_wdata,
  input wire logic gating_event_irq_enable,
  input wire logic overflow_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic auto_conv_trigger,
  input wire logic crystal_osc_enable,
  input wire logic [CNT_W-1:0] compare_value,
  input wire logic [7:0] count_low_byte,
  input wire logic [7:0] count_high_byte,
  input wire logic compare_match,
  input wire logic gating_level_status,
  input wire logic gating_event_flag,
  input wire logic overflow_flag,
  input wire logic gating_event_irq,
  input wire logic overflow_irq,
  input wire logic crystal_osc_run
);
  // ----
  // port relations
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  logic no_we;
  assign no_we = !count_low_byte_we && !count_high_byte_we;
  chk_osc_follows: assert property (crystal_osc_run == crystal_osc_enable)
    else $error("oscillator run differs");
  chk_ovf_irq_and: assert property (overflow_irq == (overflow_flag && timer_on_control
    && overflow_irq_enable && peripheral_irq_enable && global_irq_enable))
    else $error("overflow irq wrong");
  chk_gate_irq_and: assert property (gating_event_irq == (gating_event_flag
    && gating_event_irq_enable && peripheral_irq_enable && global_irq_enable))
    else $error("gate irq wrong");
  chk_match_count: assert property ($past(compare_match) == (cnt == $past(compare_value)))
    else $error("compare match wrong");
  chk_off_holds: assert property (!timer_on_control && no_we && !auto_conv_trigger
    |=> ##1 $stable(cnt)) else $error("count moved while off");
  chk_trig_clears: assert property (auto_conv_trigger && no_we |=> ##1 cnt == 16'h0000)
    else $error("trigger did not clear");
  chk_trig_no_ovf: assert property (auto_conv_trigger && !overflow_flag |=> !overflow_flag)
    else $error("trigger set overflow");
  chk_write_wins: assert property (count_low_byte_we && count_high_byte_we
    |=> ##1 cnt == {2{$past(count_wdata, 2)}}) else $error("write lost");
  chk_fall_flags: assert property ($fell(gating_level_status) |-> ##[1:2] gating_event_flag)
    else $error("gate fall not flagged");
endmodule : gtc_props
bind gtc_timer gtc_props #(.CNT_W(CNT_W)) u_props (.*);

// file: test/gtc_partner.sv
`timescale 1ns/10ps
module gtc_partner (
  input wire logic sys_clk,
  output logic timer_clock,
  output logic gating_pin,
  output logic [7:0] eight_bit_timer_count,
  output logic comparator_one_out,
  output logic comparator_two_out
);
  // ----
  // gate sources, timer clock and timer0
  // ----
  initial begin
    {timer_clock, gating_pin, comparator_one_out, comparator_two_out} = 4'h0;
    eight_bit_timer_count = 8'h00;
  end
  // timer clock pulses, three cycles high and four low between pulses, three low after the last
  task automatic tclk(input int n);
    repeat (n) begin
      @(negedge sys_clk) timer_clock = 1'b1;
      repeat (3) @(negedge sys_clk);
      timer_clock = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
  endtask : tclk
  // timer0 rolls from FFh to 00h once
  task automatic t0_wrap();
    @(negedge sys_clk) eight_bit_timer_count = 8'hFF;
    @(negedge sys_clk) eight_bit_timer_count = 8'h00;
  endtask : t0_wrap
endmodule : gtc_partner

// file: test/gtc_timer_tb.sv
`timescale 1ns/10ps
module gtc_timer_tb;
  logic sys_clk, rst_n, timer_clock, gating_pin, comparator_one_out, comparator_two_out;
  logic cmp_one_sync_enable, cmp_two_sync_enable, timer_on_control, gating_enable;
  logic gating_polarity, gating_toggle_mode, gating_single_pulse_mode, sync_disable_control;
  logic clock_source_external, crystal_osc_enable, sleep_mode, go_set, go_clear;
  logic count_low_byte_we, count_high_byte_we, gating_event_irq_enable, gating_event_flag_clear;
  logic overflow_irq_enable, overflow_flag_clear, peripheral_irq_enable, global_irq_enable;
  logic capture_event, auto_conv_trigger, compare_match, acquisition_go_flag, overflow_flag;
  logic gating_level_status, gating_event_flag, gating_event_irq, overflow_irq;
  logic wake_request, crystal_osc_run;
  logic [1:0] gating_source_select;
  logic [7:0] eight_bit_timer_count, count_wdata, count_low_byte, count_high_byte;
  logic [7:0] capture_compare_low, capture_compare_high;
  logic [15:0] compare_value;
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  int n_errors = 0;
  int compares = 0;
  gtc_timer dut (.*);
  gtc_partner u_far (.*);
  // ----
  // helpers
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  // timer stopped while both bytes are loaded
  task automatic load(input logic [15:0] v);
    timer_on_control = 1'b0;
    count_high_byte_we = 1'b1;
    count_wdata = v[15:8];
    cyc(1);
    {count_high_byte_we, count_low_byte_we} = 2'h1;
    count_wdata = v[7:0];
    cyc(1);
    count_low_byte_we = 1'b0;
    timer_on_control = 1'b1;
    cyc(3);
  endtask : load
  task automatic run(input int n, input logic [15:0] e);
    u_far.tclk(n);
    check(cnt, e);
  endtask : run
  task automatic print_verdict();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
  // ----
  // tests
  // ----
  initial begin
    {rst_n, cmp_one_sync_enable, timer_on_control, gating_enable, gating_polarity,
      gating_toggle_mode, gating_single_pulse_mode, sync_disable_control, sleep_mode,
      clock_source_external, go_set, go_clear, count_low_byte_we, count_high_byte_we,
      gating_event_irq_enable, gating_event_flag_clear, overflow_irq_enable,
      overflow_flag_clear, peripheral_irq_enable, global_irq_enable, capture_event,
      auto_conv_trigger} = '0;
    {cmp_two_sync_enable, crystal_osc_enable} = 2'h3;
    {gating_source_select, count_wdata, compare_value} = '0;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    load(16'h0000);
    run(5, 16'h0005);
    check(crystal_osc_run, 1'b1);
    gating_enable = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        gating_polarity = p[0];
        u_far.gating_pin = l[0];
        load(16'h0000);
        run(3, (p == l) ? 16'h0003 : 16'h0000);
      end
    end
    for (int s = 0; s < 4; s++) begin
      gating_source_select = s[1:0];
      {u_far.gating_pin, u_far.comparator_one_out, u_far.comparator_two_out} =
        {s == 0, s == 2, s == 3};
      u_far.tclk(1);
      load(16'h0000);
      run(3, (s == 1) ? 16'h0000 : 16'h0003);
    end
    {cmp_one_sync_enable, cmp_two_sync_enable, gating_source_select} = 4'hA;
    u_far.comparator_one_out = 1'b1;
    load(16'h0000);
    check(gating_level_status, 1'b0);
    run(1, 16'h0000);
    run(2, 16'h0002);
    {u_far.comparator_two_out, gating_source_select} = 3'h1;
    gating_toggle_mode = 1'b1;
    load(16'h0000);
    u_far.t0_wrap();
    cyc(4);
    run(3, 16'h0003);
    gating_toggle_mode = 1'b0;
    cyc(3);
    run(2, 16'h0003);
    gating_toggle_mode = 1'b1;
    u_far.t0_wrap();
    cyc(4);
    pulse(timer_on_control);
    timer_on_control = 1'b1;
    run(2, 16'h0003);
    {gating_toggle_mode, gating_source_select} = 3'h0;
    gating_single_pulse_mode = 1'b1;
    load(16'h0000);
    pulse(go_set);
    check(acquisition_go_flag, 1'b1);
    run(2, 16'h0000);
    u_far.gating_pin = 1'b1;
    cyc(3);
    run(3, 16'h0003);
    u_far.gating_pin = 1'b0;
    cyc(4);
    check(acquisition_go_flag, 1'b0);
    u_far.gating_pin = 1'b1;
    cyc(3);
    run(3, 16'h0003);
    gating_single_pulse_mode = 1'b0;
    pulse(go_clear);
    {gating_enable, gating_event_irq_enable, peripheral_irq_enable, global_irq_enable} = 4'h7;
    pulse(gating_event_flag_clear);
    check({gating_level_status, gating_event_flag}, 2'h2);
    u_far.gating_pin = 1'b0;
    cyc(4);
    check({gating_event_flag, gating_event_irq}, 2'h3);
    overflow_irq_enable = 1'b1;
    load(16'hFFFE);
    run(2, 16'h0000);
    check({overflow_flag, overflow_irq}, 2'h3);
    {global_irq_enable, sleep_mode, clock_source_external} = 3'h3;
    cyc(1);
    check({overflow_irq, wake_request}, 2'h1);
    run(2, 16'h0000);
    sync_disable_control = 1'b1;
    run(1, 16'h0001);
    {sleep_mode, sync_disable_control} = 2'h0;
    pulse(overflow_flag_clear);
    check(overflow_flag, 1'b0);
    load(16'h1234);
    pulse(capture_event);
    check({capture_compare_high, capture_compare_low}, 16'h1234);
    compare_value = 16'h1234;
    cyc(1);
    check(compare_match, 1'b1);
    pulse(auto_conv_trigger);
    check(cnt, 16'h0000);
    check(overflow_flag, 1'b0);
    count_wdata = 8'h5A;
    {count_high_byte_we, count_low_byte_we, auto_conv_trigger} = 3'h7;
    cyc(1);
    {count_high_byte_we, count_low_byte_we, auto_conv_trigger} = 3'h0;
    cyc(2);
    check(cnt, 16'h5A5A);
    print_verdict();
  end
endmodule : gtc_timer_tb
